/* logic/pio_defines.svh */
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

`define PIO_NPINS 53
`define PIO_NPORTS 8
// register byte offsets, one group of eight ports per field kind
`define PIO_OFS_LATCH 8'h00
`define PIO_OFS_ADSEL 8'h20
`define PIO_OFS_MODE 8'h40
`define PIO_OFS_SKIP 8'h60
`define PIO_OFS_DRV 8'h80
`define PIO_OFS_GCTL 8'ha0
// reset values
`define PIO_RST_LATCH 8'hff
`define PIO_RST_ADSEL 8'hff
`define PIO_RST_MODE 8'h00
`define PIO_RST_SKIP 8'h00
`define PIO_RST_DRV 8'h00
`define PIO_GCTL_PUD_BIT 0
// fixed function pin indices (port*8+bit); the debug pin is always digital
`define PIO_PIN_VREF 6'd0
`define PIO_PIN_ANALOG_GROUND_REFERENCE 6'd1
`define PIO_PIN_XIN 6'd2
`define PIO_PIN_XOUT 6'd3
`define PIO_PIN_IREF 6'd7
`define PIO_PIN_PCNT0 6'd8
`define PIO_PIN_PCNT1 6'd9
`define PIO_PIN_DBG 6'd52
`define PIO_XBAR_LAST 6'd22
`define PIO_MUX_A_LAST 6'd7
`define PIO_MUX_B_FIRST 6'd12
`define PIO_MUX_B_LAST 6'd19
`define PIO_LCD_FIRST 6'd20
`define PIO_LCD_LAST 6'd55
`endif

/* logic/pio_pkg.sv */
package pio_pkg;
  typedef enum logic [1:0] {
    PIO_FIELD_LATCH = 2'h0,
    PIO_FIELD_ADSEL = 2'h1,
    PIO_FIELD_MODE = 2'h2,
    PIO_FIELD_SKIP = 2'h3
  } pio_field_t;
  typedef enum logic [1:0] {
    PIO_BUS_IDLE = 2'b00,
    PIO_BUS_ACK = 2'b01
  } pio_bus_state_t;
endpackage

/* logic/pio_cell.sv */
`timescale 1ns/1ps
// one pad cell: driver, pull-up and receiver
module pio_cell (
  input wire logic latch_i,
  input wire logic digital_i,
  input wire logic push_pull_i,
  input wire logic pud_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic pullup_o,
  output logic read_o
);
  logic drive_low;
  assign drive_low = digital_i && !latch_i;
  assign pad_oe_o = drive_low || (digital_i && push_pull_i);
  assign pad_o = latch_i;
  // pull-up when floating; global off; analog off
  assign pullup_o = digital_i && !pud_i && !pad_oe_o;
  // pad level read; analog reads zero
  assign read_o = digital_i && pad_i;
endmodule

/* logic/pio_wb_slave.sv */
`timescale 1ns/1ps
// classic wishbone handshake: one-cycle ack, blocks back-to-back re-ack
module pio_wb_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic take_o
);
  pio_pkg::pio_bus_state_t st_q;
  assign take_o = cyc_i && stb_i && (st_q == pio_pkg::PIO_BUS_IDLE);
  assign ack_o = (st_q == pio_pkg::PIO_BUS_ACK);
  // ack one cycle after request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= pio_pkg::PIO_BUS_IDLE;
    end else begin
      case (st_q)
        pio_pkg::PIO_BUS_IDLE: st_q <= take_o ? pio_pkg::PIO_BUS_ACK : pio_pkg::PIO_BUS_IDLE;
        pio_pkg::PIO_BUS_ACK: st_q <= pio_pkg::PIO_BUS_IDLE;
        default: st_q <= pio_pkg::PIO_BUS_IDLE;
      endcase
    end
  end
endmodule

/* logic/pio_port.sv */
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "pio_defines.svh"
// 53-pin port block with wishbone registers
module pio_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [63:0] pad_i,
  output logic [63:0] pad_o,
  output logic [63:0] pad_oe_o,
  output logic [63:0] pullup_o,
  output logic [63:0] drive_high_o,
  output logic [63:0] analog_en_o,
  output logic [63:0] xbar_avail_o,
  output logic [63:0] pin_read_o
);
  logic [63:0] latch_q;
  logic [63:0] adsel_q;
  logic [63:0] mode_q;
  logic [63:0] skip_q;
  logic [63:0] drv_q;
  logic pud_q;
  logic [63:0] valid_pin;
  logic [63:0] digital;
  logic [63:0] read_raw;
  logic [63:0] oe_raw;
  logic [63:0] o_raw;
  logic [63:0] pu_raw;
  logic take;
  logic wr;
  logic [2:0] port_sel;
  logic [7:0] grp;
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic [7:0] rd_byte;

  pio_wb_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .ack_o(wb_ack_o),
    .take_o(take)
  );

  // byte lane 0 carries the port byte; write lands on the acknowledging edge,
  // so a master that drops the cycle before ack leaves the registers untouched
  assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign port_sel = wb_adr_i[4:2];
  assign grp = {wb_adr_i[7:5], 5'h00};

  genvar i;
  generate
    for (i = 0; i < 64; i = i + 1) begin : g_pin
      assign valid_pin[i] = (i < `PIO_NPINS);
      assign digital[i] = valid_pin[i] && (adsel_q[i] || (i == `PIO_PIN_DBG));
      pio_cell u_cell (
        .latch_i(latch_q[i]),
        .digital_i(digital[i]),
        .push_pull_i(mode_q[i]),
        .pud_i(pud_q),
        .pad_i(pad_i[i]),
        .pad_o(o_raw[i]),
        .pad_oe_o(oe_raw[i]),
        .pullup_o(pu_raw[i]),
        .read_o(read_raw[i])
      );
      assign pad_o[i] = o_raw[i];
      assign pad_oe_o[i] = oe_raw[i];
      assign pullup_o[i] = pu_raw[i];
      assign drive_high_o[i] = valid_pin[i] && drv_q[i];
      // analog path on select 0, except pin 52 (debug) which is always digital
      assign analog_en_o[i] = valid_pin[i] && !digital[i];
      // skipped pins withheld; low range only
      assign xbar_avail_o[i] = (i <= `PIO_XBAR_LAST) && !skip_q[i];
      assign pin_read_o[i] = read_raw[i];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= {8{`PIO_RST_LATCH}};
    end else if (wr && grp == `PIO_OFS_LATCH) begin
      latch_q[port_sel*8 +: 8] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adsel_q <= {8{`PIO_RST_ADSEL}};
    end else if (wr && grp == `PIO_OFS_ADSEL) begin
      adsel_q[port_sel*8 +: 8] <= wb_dat_i[7:0];
    end
  end

  // open-drain with latch high is high-z
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= {8{`PIO_RST_MODE}};
    end else if (wr && grp == `PIO_OFS_MODE) begin
      mode_q[port_sel*8 +: 8] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_q <= {8{`PIO_RST_SKIP}};
    end else if (wr && grp == `PIO_OFS_SKIP) begin
      skip_q[port_sel*8 +: 8] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_q <= {8{`PIO_RST_DRV}};
    end else if (wr && grp == `PIO_OFS_DRV) begin
      drv_q[port_sel*8 +: 8] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pud_q <= 1'b0;
    end else if (wr && wb_adr_i == `PIO_OFS_GCTL) begin
      pud_q <= wb_dat_i[`PIO_GCTL_PUD_BIT];
    end
  end

  // read mux: bits of absent pins read zero
  always_comb begin
    rd_byte = 8'h00;
    case (grp)
      `PIO_OFS_LATCH: rd_byte = pin_read_o[port_sel*8 +: 8];
      `PIO_OFS_ADSEL: rd_byte = adsel_q[port_sel*8 +: 8] & valid_pin[port_sel*8 +: 8];
      `PIO_OFS_MODE: rd_byte = mode_q[port_sel*8 +: 8] & valid_pin[port_sel*8 +: 8];
      `PIO_OFS_SKIP: rd_byte = skip_q[port_sel*8 +: 8] & valid_pin[port_sel*8 +: 8];
      `PIO_OFS_DRV: rd_byte = drv_q[port_sel*8 +: 8] & valid_pin[port_sel*8 +: 8];
      `PIO_OFS_GCTL: rd_byte = (port_sel == 3'h0) ? {7'h00, pud_q} : 8'h00;
      default: rd_byte = 8'h00;
    endcase
    rd_d = {24'h000000, rd_byte};
  end

  // read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 32'h00000000;
    end else if (take) begin
      rd_q <= rd_d;
    end
  end
  assign wb_dat_o = rd_q;
endmodule

/* verification/pio_port_monitor.sv */
`timescale 1ns/1ps
// pin cell and bus handshake relations seen at the block's ports
module pio_port_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [63:0] pad_i,
  input wire logic [63:0] pad_o,
  input wire logic [63:0] pad_oe_o,
  input wire logic [63:0] pullup_o,
  input wire logic [63:0] analog_en_o,
  input wire logic [63:0] xbar_avail_o,
  input wire logic [63:0] pin_read_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // first sample after release: all pins idle with pull-ups
  reset_idle_a: assert property ($fell(rst_i) |-> &pullup_o[52:0] && !(|pad_oe_o[52:0]))
    else $error("pins not idle after reset");
  analog_quiet_a: assert property (!(|(analog_en_o & (pullup_o | pin_read_o))))
    else $error("analog pin has pull-up or reads high");
  low_no_pull_a: assert property (!(|(pad_oe_o & ~pad_o & pullup_o)))
    else $error("pull-up on while driving low");
  pad_read_a: assert property (!(|(~analog_en_o[52:0] & (pin_read_o[52:0] ^ pad_i[52:0]))))
    else $error("digital read differs from pad");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_next_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  pud_all_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'ha0 && wb_sel_i[0]
    && wb_dat_i[0] |=> pullup_o == 64'h0) else $error("global disable left a pull-up on");
  xbar_range_a: assert property (xbar_avail_o[63:23] == 41'h0)
    else $error("crossbar offered a pin past its range");
  last_digital_a: assert property (!analog_en_o[52])
    else $error("last pin in analog mode");
endmodule

bind pio_port pio_port_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
  .pullup_o(pullup_o), .analog_en_o(analog_en_o), .xbar_avail_o(xbar_avail_o),
  .pin_read_o(pin_read_o));

/* verification/pio_pad_model.sv */
`timescale 1ns/1ps
// board side: cell drive wins, then board driver, then pull-up
module pio_pad_model (
  input wire logic clk_i,
  input wire logic [63:0] pad_o_i,
  input wire logic [63:0] oe_i,
  input wire logic [63:0] pu_i,
  input wire logic [63:0] ext_en_i,
  input wire logic [63:0] ext_v_i,
  output logic [63:0] pad_i_o
);
  logic [63:0] last_q = '0;
  // a floating line toggles so a stale level never passes as good
  always_comb pad_i_o = (oe_i & pad_o_i) | (~oe_i & ext_en_i & ext_v_i)
    | (~oe_i & ~ext_en_i & (pu_i | ~last_q));
  always_ff @(posedge clk_i) last_q <= pad_i_o;
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, lanes = 4'h1;
  logic [31:0] wd = 32'h0, rdat, rd_q;
  logic [63:0] pi, po, oe, pu, drv, an, xb, pr, ext_en = '0, ext_v = '0;
  int bad_count = 0, total_checks = 0;
  always #5 clk_i = ~clk_i;
  pio_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pad_i(pi), .pad_o(po), .pad_oe_o(oe), .pullup_o(pu), .drive_high_o(drv),
    .analog_en_o(an), .xbar_avail_o(xb), .pin_read_o(pr));
  pio_pad_model u_pads (.clk_i(clk_i), .pad_o_i(po), .oe_i(oe), .pu_i(pu), .ext_en_i(ext_en),
    .ext_v_i(ext_v), .pad_i_o(pi));
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask
  // one classic cycle; held until ack, then released for one cycle
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    cyc <= 1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wd <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      conclude;
    end
    rd_q = rdat;
    cyc <= 0;
    we <= 0;
    sel <= 4'h0;
    @(posedge clk_i);
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    chk(rd_q, {56'h0, e});
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(pu[52:0], {11'h0, {53{1'b1}}});
    chk(oe | an | drv, 64'h0);
    rc(8'h20, 8'hff);
    // board drives port 0 so reads show the pad, not the latch
    ext_en[7:0] <= 8'hff;
    ext_v[7:0] <= 8'h5a;
    rc(8'h00, 8'h5a);
    // park analog pins: skipped, open-drain, latch high
    acc(1, 8'h60, 8'hf0);
    acc(1, 8'h20, 8'h0f);
    rc(8'h00, 8'h0a);
    chk({an[7:0], pu[7:4]}, {8'hf0, 4'h0});
    chk(xb, 64'h7fff0f);
    ext_en <= '0;
    acc(1, 8'h04, 8'h0f);
    chk({oe[15:8], pu[15:8]}, 16'hf00f);
    rc(8'h04, 8'h0f);
    acc(1, 8'h44, 8'hff);
    chk({oe[15:8], po[15:8]}, 16'hff0f);
    acc(1, 8'ha0, 8'h01);
    chk(pu, 64'h0);
    acc(1, 8'ha0, 8'h00);
    acc(1, 8'h88, 8'ha5);
    chk(drv, 64'ha50000);
    // lane 0 off: the write is acked but must not land
    lanes = 4'he;
    acc(1, 8'h88, 8'h00);
    lanes = 4'h1;
    chk(drv, 64'ha50000);
    acc(1, 8'h38, 8'h00);
    chk(an[52:48], 5'h0f);
    // unmapped place: write ignored, reads zero
    acc(1, 8'hc0, 8'hff);
    rc(8'hc0, 8'h00);
    // mid-run reset must put every configured pin back to idle
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(pu[52:0], {11'h0, {53{1'b1}}});
    chk(oe | an | drv, 64'h0);
    rc(8'h20, 8'hff);
    conclude;
  end
endmodule
